// ===== hdl/scmr_pkg.sv
// Constants and carrier types for the stop-mode clock-loss recovery block
package scmr_pkg;

  // ------------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------------
  localparam logic [12:0] OSC_GOOD_CYCLES = 13'h1000;
  localparam logic [5:0] MAX_CHECK_WINDOWS = 6'h32;
  localparam int unsigned CHECK_WINDOW_DEFAULT = 16384;

  // ------------------------------------------------------------------
  // Reset vectors and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] VEC_POWER_EXT = 16'hfffe;
  localparam logic [15:0] VEC_CLOCK_MONITOR = 16'hfffc;
  localparam logic [15:0] VEC_WATCHDOG = 16'hfffa;
  localparam logic [15:0] VEC_RESET_VALUE = 16'hfffe;
  localparam logic RST_SELF_CLOCK_MODE = 1'b0;
  localparam logic RST_PLL_CLOCK_SELECT = 1'b0;
  localparam logic RST_SELF_CLOCK_IRQ_FLAG = 1'b0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_FULL_STOP = 3'b001,
    ST_FULL_CHECK = 3'b011,
    ST_PSEUDO_STOP = 3'b010
  } scmr_state_e;

  typedef struct packed {
    logic clock_monitor_enable;
    logic self_clock_mode_enable;
    logic self_clock_irq_enable;
    logic pseudo_stop_select;
    logic low_voltage_detect_enable;
    logic low_voltage_reset_enable;
    logic [2:0] watchdog_rate_field;
  } scmr_cfg_s;

  typedef struct packed {
    logic power_on;
    logic low_voltage;
    logic external;
    logic watchdog_timeout;
  } scmr_rst_src_s;

  typedef struct packed {
    logic power_ext;
    logic clock_monitor;
    logic watchdog;
  } scmr_cause_s;

  typedef struct packed {
    logic ok;
    logic timeout;
    logic [5:0] windows;
  } scmr_check_s;

endpackage

// ===== hdl/scmr_quality_check.sv
// Oscillator quality checker: check windows, good-run counter, timeout
`timescale 1ns/10ps
module scmr_quality_check #(
  parameter int unsigned WINDOW_CYCLES = scmr_pkg::CHECK_WINDOW_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic i_run,
  input wire logic i_limited,
  // Oscillator observation
  input wire logic i_osc_tick,
  input wire logic i_osc_fail,
  // Result
  output scmr_pkg::scmr_check_s o_check
);

  localparam logic [15:0] WIN_LAST = 16'(WINDOW_CYCLES - 1);
  localparam logic [12:0] GOOD_LAST = scmr_pkg::OSC_GOOD_CYCLES - 13'h0001;
  localparam logic [5:0] WINDOWS_LAST = scmr_pkg::MAX_CHECK_WINDOWS - 6'h01;

  logic active;
  logic next_active;
  logic [15:0] win_cnt;
  logic [15:0] next_win_cnt;
  logic [12:0] good_cnt;
  logic [12:0] next_good_cnt;
  scmr_pkg::scmr_check_s check;
  scmr_pkg::scmr_check_s next_check;

  // ------------------------------------------------------------------
  // Window sequencing
  // ------------------------------------------------------------------
  // Window must span at least 4096 oscillator ticks, or no window can pass
  always_comb begin
    next_active = active;
    next_win_cnt = win_cnt;
    next_good_cnt = good_cnt;
    next_check = check;
    next_check.ok = 1'b0;
    next_check.timeout = 1'b0;
    if (i_start) begin
      next_active = 1'b1;
      next_win_cnt = 16'h0000;
      next_good_cnt = 13'h0000;
      next_check.windows = 6'h00;
    end else if (i_run && active) begin
      if (i_osc_fail) begin
        next_good_cnt = 13'h0000;
      end else if (i_osc_tick) begin
        next_good_cnt = good_cnt + 13'h0001;
      end
      if (!i_osc_fail && i_osc_tick && good_cnt == GOOD_LAST) begin
        next_check.ok = 1'b1;
        next_active = 1'b0;
      end else if (win_cnt == WIN_LAST) begin
        next_win_cnt = 16'h0000;
        next_good_cnt = 13'h0000;
        if (i_limited && check.windows == WINDOWS_LAST) begin
          next_check.timeout = 1'b1;
          next_active = 1'b0;
        end else if (check.windows != 6'h3f) begin
          // Unlimited checks run on forever; the count just saturates
          next_check.windows = check.windows + 6'h01;
        end
      end else begin
        next_win_cnt = win_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active <= 1'b0;
      win_cnt <= 16'h0000;
      good_cnt <= 13'h0000;
      check <= '0;
    end else begin
      active <= next_active;
      win_cnt <= next_win_cnt;
      good_cnt <= next_good_cnt;
      check <= next_check;
    end
  end

  assign o_check = check;

endmodule

// ===== hdl/scmr_stop_recovery.sv
// Stop-mode clock-loss supervision, wake-up sequencing and reset vectoring
`timescale 1ns/10ps
module scmr_stop_recovery #(
  parameter int unsigned CHECK_WINDOW_CYCLES = scmr_pkg::CHECK_WINDOW_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration bits
  input scmr_pkg::scmr_cfg_s i_cfg,
  // Core requests and software actions
  input wire logic i_stop_req,
  input wire logic i_wake_irq,
  input wire logic i_pll_clock_select_set,
  input wire logic i_self_clock_irq_flag_clear,
  // Oscillator and clock monitor
  input wire logic i_osc_tick,
  input wire logic i_osc_fail,
  // Reset sources
  input scmr_pkg::scmr_rst_src_s i_rst_src,
  // Clock control
  output logic o_self_clock_mode,
  output logic o_pll_enable,
  output logic o_voltage_regulator_enable,
  output logic o_pll_clock_select,
  output logic o_system_clock_pll,
  output logic o_clocks_released,
  output logic o_stopped,
  // Interrupt
  output logic o_self_clock_irq_flag,
  output logic o_self_clock_wake_irq,
  // Reset request
  output logic o_reset_req,
  output logic o_clock_monitor_reset,
  output logic [15:0] o_reset_vector,
  output scmr_pkg::scmr_cause_s o_reset_cause,
  // Quality check status
  output logic [5:0] o_check_windows
);

  scmr_pkg::scmr_state_e state;
  scmr_pkg::scmr_state_e next_state;
  logic self_clock_mode;
  logic next_scm;
  logic flag;
  logic next_flag;
  logic pll_sel;
  logic next_pll_sel;
  logic wake_by_reset;
  logic next_wake_by_reset;
  logic reset_req;
  logic next_reset_req;
  logic cmr_pulse;
  logic next_cmr_pulse;
  logic ck_start;
  logic next_ck_start;
  logic [15:0] vector;
  logic [15:0] next_vector;
  scmr_pkg::scmr_cause_s cause;
  scmr_pkg::scmr_cause_s next_cause;

  logic monitor_active;
  logic clock_fail;
  logic normal_src;
  logic wdog_src;
  logic cmr_event;
  logic scm_entry;
  logic ck_run;
  logic ck_limited;
  scmr_pkg::scmr_check_s chk;

  // ------------------------------------------------------------------
  // Clock monitor and reset source decode
  // ------------------------------------------------------------------
  // The monitor is off in full stop and during the wake-up check window
  assign monitor_active = i_cfg.clock_monitor_enable && state != scmr_pkg::ST_FULL_STOP
                          && state != scmr_pkg::ST_FULL_CHECK;
  assign clock_fail = monitor_active && i_osc_fail;
  assign normal_src = i_rst_src.power_on || i_rst_src.external
                      || (i_rst_src.low_voltage && i_cfg.low_voltage_detect_enable
                          && i_cfg.low_voltage_reset_enable);
  assign wdog_src = i_rst_src.watchdog_timeout && i_cfg.watchdog_rate_field != 3'h0;
  assign cmr_event = clock_fail && !i_cfg.self_clock_mode_enable;
  assign scm_entry = clock_fail && i_cfg.self_clock_mode_enable && !self_clock_mode;

  // Checks run while in self-clock mode, but an ongoing check is frozen in full stop
  assign ck_run = (self_clock_mode && state != scmr_pkg::ST_FULL_STOP)
                  || state == scmr_pkg::ST_FULL_CHECK;
  assign ck_limited = state == scmr_pkg::ST_FULL_CHECK;

  // ------------------------------------------------------------------
  // Quality checker
  // ------------------------------------------------------------------
  scmr_quality_check #(
    .WINDOW_CYCLES(CHECK_WINDOW_CYCLES)
  ) u_check (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(ck_start),
    .i_run(ck_run),
    .i_limited(ck_limited),
    .i_osc_tick(i_osc_tick),
    .i_osc_fail(i_osc_fail),
    .o_check(chk)
  );

  // ------------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_scm = self_clock_mode;
    next_flag = flag;
    next_pll_sel = pll_sel;
    next_wake_by_reset = wake_by_reset;
    next_reset_req = 1'b0;
    next_cmr_pulse = 1'b0;
    next_ck_start = 1'b0;
    next_vector = vector;
    next_cause = cause;
    if (i_pll_clock_select_set) begin
      next_pll_sel = 1'b1;
    end
    // Flag clear comes first so a same-cycle set below wins
    if (i_self_clock_irq_flag_clear) begin
      next_flag = 1'b0;
    end
    // Good oscillator leaves self-clock wherever the check is running
    if (chk.ok && self_clock_mode && state != scmr_pkg::ST_FULL_CHECK) begin
      next_scm = 1'b0;
    end
    unique case (state)
      scmr_pkg::ST_RUN: begin
        if (normal_src) begin
          next_reset_req = 1'b1;
          next_vector = scmr_pkg::VEC_POWER_EXT;
          next_cause = '{power_ext: 1'b1, clock_monitor: 1'b0, watchdog: 1'b0};
          next_flag = scmr_pkg::RST_SELF_CLOCK_IRQ_FLAG;
          next_pll_sel = scmr_pkg::RST_PLL_CLOCK_SELECT;
        end else if (cmr_event) begin
          next_reset_req = 1'b1;
          next_cmr_pulse = 1'b1;
          next_vector = scmr_pkg::VEC_CLOCK_MONITOR;
          next_cause = '{power_ext: 1'b0, clock_monitor: 1'b1, watchdog: 1'b0};
          next_pll_sel = scmr_pkg::RST_PLL_CLOCK_SELECT;
        end else if (wdog_src) begin
          next_reset_req = 1'b1;
          next_vector = scmr_pkg::VEC_WATCHDOG;
          next_cause = '{power_ext: 1'b0, clock_monitor: 1'b0, watchdog: 1'b1};
          next_pll_sel = scmr_pkg::RST_PLL_CLOCK_SELECT;
        end else if (scm_entry) begin
          next_scm = 1'b1;
          next_ck_start = 1'b1;
          next_flag = 1'b1;
        end else if (i_stop_req) begin
          // The PLL is powered down in stop unless self-clock mode holds it, so the select cannot survive it
          next_pll_sel = 1'b0;
          if (i_cfg.pseudo_stop_select) begin
            next_state = scmr_pkg::ST_PSEUDO_STOP;
          end else begin
            next_state = scmr_pkg::ST_FULL_STOP;
          end
        end
      end
      scmr_pkg::ST_PSEUDO_STOP: begin
        if (normal_src) begin
          // Exit keeps self-clock mode if the oscillator is still bad
          next_state = scmr_pkg::ST_RUN;
          next_reset_req = 1'b1;
          next_vector = scmr_pkg::VEC_POWER_EXT;
          next_cause = '{power_ext: 1'b1, clock_monitor: 1'b0, watchdog: 1'b0};
          next_flag = scmr_pkg::RST_SELF_CLOCK_IRQ_FLAG;
          next_pll_sel = scmr_pkg::RST_PLL_CLOCK_SELECT;
        end else if (cmr_event) begin
          next_state = scmr_pkg::ST_RUN;
          next_reset_req = 1'b1;
          next_cmr_pulse = 1'b1;
          next_vector = scmr_pkg::VEC_CLOCK_MONITOR;
          next_cause = '{power_ext: 1'b0, clock_monitor: 1'b1, watchdog: 1'b0};
          next_pll_sel = 1'b0;
        end else if (wdog_src) begin
          next_state = scmr_pkg::ST_RUN;
          next_reset_req = 1'b1;
          next_vector = scmr_pkg::VEC_WATCHDOG;
          next_cause = '{power_ext: 1'b0, clock_monitor: 1'b0, watchdog: 1'b1};
          next_pll_sel = 1'b0;
        end else if (scm_entry) begin
          next_scm = 1'b1;
          next_ck_start = 1'b1;
          next_flag = 1'b1;
          if (i_cfg.self_clock_irq_enable) begin
            next_state = scmr_pkg::ST_RUN;
          end
        end else if (i_wake_irq) begin
          next_state = scmr_pkg::ST_RUN;
          next_pll_sel = 1'b0;
        end
      end
      scmr_pkg::ST_FULL_STOP: begin
        if (normal_src) begin
          // Configuration back to defaults before the check windows start
          next_state = scmr_pkg::ST_FULL_CHECK;
          next_wake_by_reset = 1'b1;
          next_ck_start = 1'b1;
          next_flag = scmr_pkg::RST_SELF_CLOCK_IRQ_FLAG;
          next_pll_sel = scmr_pkg::RST_PLL_CLOCK_SELECT;
          next_scm = scmr_pkg::RST_SELF_CLOCK_MODE;
        end else if (i_wake_irq) begin
          next_state = scmr_pkg::ST_FULL_CHECK;
          next_wake_by_reset = 1'b0;
          next_ck_start = 1'b1;
        end
      end
      scmr_pkg::ST_FULL_CHECK: begin
        next_pll_sel = 1'b0;
        if (chk.ok) begin
          next_state = scmr_pkg::ST_RUN;
          next_scm = 1'b0;
          if (wake_by_reset) begin
            next_reset_req = 1'b1;
            next_vector = scmr_pkg::VEC_POWER_EXT;
            next_cause = '{power_ext: 1'b1, clock_monitor: 1'b0, watchdog: 1'b0};
          end
        end else if (chk.timeout) begin
          next_state = scmr_pkg::ST_RUN;
          if (wake_by_reset) begin
            // A reset wake runs its sequence on the self clock
            next_scm = 1'b1;
            next_ck_start = 1'b1;
            next_reset_req = 1'b1;
            next_vector = scmr_pkg::VEC_POWER_EXT;
            next_cause = '{power_ext: 1'b1, clock_monitor: 1'b0, watchdog: 1'b0};
          end else if (!i_cfg.self_clock_mode_enable) begin
            next_reset_req = 1'b1;
            next_cmr_pulse = 1'b1;
            next_vector = scmr_pkg::VEC_CLOCK_MONITOR;
            next_cause = '{power_ext: 1'b0, clock_monitor: 1'b1, watchdog: 1'b0};
          end else begin
            next_scm = 1'b1;
            next_ck_start = 1'b1;
          end
        end else if (normal_src) begin
          // External reset during the check turns the wake into a reset wake
          next_wake_by_reset = 1'b1;
          next_flag = 1'b0;
        end
      end
      default: begin
        next_state = scmr_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= scmr_pkg::ST_RUN;
      self_clock_mode <= scmr_pkg::RST_SELF_CLOCK_MODE;
      flag <= scmr_pkg::RST_SELF_CLOCK_IRQ_FLAG;
      pll_sel <= scmr_pkg::RST_PLL_CLOCK_SELECT;
      wake_by_reset <= 1'b0;
      reset_req <= 1'b0;
      cmr_pulse <= 1'b0;
      ck_start <= 1'b0;
      vector <= scmr_pkg::VEC_RESET_VALUE;
      cause <= '0;
    end else begin
      state <= next_state;
      self_clock_mode <= next_scm;
      flag <= next_flag;
      pll_sel <= next_pll_sel;
      wake_by_reset <= next_wake_by_reset;
      reset_req <= next_reset_req;
      cmr_pulse <= next_cmr_pulse;
      ck_start <= next_ck_start;
      vector <= next_vector;
      cause <= next_cause;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Regulator stays up whenever self-clock mode needs the PLL, even in stop
  assign o_self_clock_mode = self_clock_mode;
  assign o_pll_enable = self_clock_mode || pll_sel;
  assign o_voltage_regulator_enable = self_clock_mode || state == scmr_pkg::ST_RUN
                         || state == scmr_pkg::ST_FULL_CHECK;
  assign o_pll_clock_select = pll_sel;
  assign o_system_clock_pll = self_clock_mode || pll_sel;
  assign o_clocks_released = state == scmr_pkg::ST_RUN;
  assign o_stopped = state != scmr_pkg::ST_RUN;
  assign o_self_clock_irq_flag = flag;
  assign o_self_clock_wake_irq = flag && i_cfg.self_clock_irq_enable;
  assign o_reset_req = reset_req;
  assign o_clock_monitor_reset = cmr_pulse;
  assign o_reset_vector = vector;
  assign o_reset_cause = cause;
  assign o_check_windows = chk.windows;

endmodule

// ===== testbench/scmr_stop_recovery_asserts.sv
// Concurrent checks on the stop-recovery ports, bound into every instance
`timescale 1ns/10ps
module scmr_stop_recovery_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Block inputs
  input scmr_pkg::scmr_cfg_s i_cfg,
  input wire logic i_wake_irq,
  input wire logic i_osc_fail,
  input scmr_pkg::scmr_rst_src_s i_rst_src,
  // Block outputs
  input wire logic o_self_clock_mode,
  input wire logic o_pll_enable,
  input wire logic o_voltage_regulator_enable,
  input wire logic o_pll_clock_select,
  input wire logic o_clocks_released,
  input wire logic o_stopped,
  input wire logic o_self_clock_irq_flag,
  input wire logic o_self_clock_wake_irq,
  input wire logic o_reset_req,
  input wire logic o_clock_monitor_reset,
  input wire logic [15:0] o_reset_vector,
  input scmr_pkg::scmr_cause_s o_reset_cause
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Quiet stop: no reset source competes with the monitor decision
  wire in_pseudo = o_stopped && i_cfg.pseudo_stop_select && i_rst_src == 4'h0;
  wire in_full = o_stopped && !i_cfg.pseudo_stop_select && i_rst_src == 4'h0 && !i_wake_irq;
  wire scm_on = i_cfg.clock_monitor_enable && i_cfg.self_clock_mode_enable;
  wire run_wd = o_clocks_released && !i_cfg.clock_monitor_enable && i_rst_src == 4'h1;

  // ------------------------------------------------------------------
  // Pseudo-stop clock loss
  // ------------------------------------------------------------------
  chk_blind_monitor: assert property (
    in_pseudo && !i_cfg.clock_monitor_enable && !o_self_clock_mode
    |=> !o_self_clock_mode && !o_reset_req)
    else $error("self clock or reset with the monitor disabled");
  chk_monitor_reset: assert property (
    in_pseudo && i_cfg.clock_monitor_enable && !i_cfg.self_clock_mode_enable && i_osc_fail
    |=> o_clock_monitor_reset && o_reset_vector == 16'hfffc && !o_stopped)
    else $error("no immediate monitor reset");
  chk_scm_stay: assert property (
    in_pseudo && scm_on && !i_cfg.self_clock_irq_enable && i_osc_fail && !i_wake_irq
    |=> o_self_clock_mode && o_self_clock_irq_flag && o_pll_enable && o_voltage_regulator_enable && o_stopped)
    else $error("self-clock entry in pseudo-stop wrong");
  chk_scm_wake: assert property (
    in_pseudo && scm_on && i_cfg.self_clock_irq_enable && i_osc_fail && !i_wake_irq
    |=> o_self_clock_irq_flag && o_self_clock_wake_irq && o_self_clock_mode)
    else $error("self-clock wake interrupt missing");
  chk_irq_gate: assert property (
    o_self_clock_wake_irq == (o_self_clock_irq_flag && i_cfg.self_clock_irq_enable))
    else $error("wake interrupt not gated by its enable");
  chk_recover_power: assert property (
    $fell(o_self_clock_mode) && o_stopped && i_cfg.pseudo_stop_select
    |-> !o_pll_enable && !o_voltage_regulator_enable)
    else $error("pll or regulator left on after recovery");

  // ------------------------------------------------------------------
  // Full stop and reset requests
  // ------------------------------------------------------------------
  chk_full_blind: assert property (
    in_full && i_osc_fail && !o_self_clock_mode |=> !o_self_clock_mode && !o_clock_monitor_reset)
    else $error("monitor reacted in full stop");
  chk_pll_sel_cleared: assert property (
    $fell(o_stopped) |-> !o_pll_clock_select)
    else $error("pll select still set after stop");
  chk_cmr_pulse: assert property (
    o_clock_monitor_reset |-> o_reset_req && o_reset_vector == 16'hfffc ##1 !o_reset_req)
    else $error("monitor reset pulse malformed");
  chk_wd_off: assert property (
    run_wd && i_cfg.watchdog_rate_field == 3'h0 |=> !o_reset_req)
    else $error("watchdog reset with rate field zero");
  chk_wd_vector: assert property (
    run_wd && i_cfg.watchdog_rate_field != 3'h0
    |=> o_reset_req && o_reset_vector == 16'hfffa && o_reset_cause.watchdog)
    else $error("watchdog reset vector wrong");
endmodule

bind scmr_stop_recovery scmr_stop_recovery_asserts u_asserts (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_wake_irq(i_wake_irq),
  .i_osc_fail(i_osc_fail), .i_rst_src(i_rst_src), .o_self_clock_mode(o_self_clock_mode),
  .o_pll_enable(o_pll_enable), .o_voltage_regulator_enable(o_voltage_regulator_enable),
  .o_pll_clock_select(o_pll_clock_select), .o_clocks_released(o_clocks_released),
  .o_stopped(o_stopped), .o_self_clock_irq_flag(o_self_clock_irq_flag),
  .o_self_clock_wake_irq(o_self_clock_wake_irq), .o_reset_req(o_reset_req),
  .o_clock_monitor_reset(o_clock_monitor_reset), .o_reset_vector(o_reset_vector),
  .o_reset_cause(o_reset_cause));

// ===== testbench/scmr_stop_recovery_test.sv
// Self-checking bench for the stop-mode clock-loss recovery block
`timescale 1ns/10ps
module scmr_stop_recovery_test;
  // Long windows let 4096 good ticks fit; short ones make a 50-window timeout cheap
  localparam int unsigned WIN = 4200;
  localparam int unsigned WIN_S = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  scmr_pkg::scmr_cfg_s i_cfg = '0;
  logic i_stop_req = 1'b0;
  logic i_wake_irq = 1'b0;
  logic i_pll_clock_select_set = 1'b0;
  logic i_self_clock_irq_flag_clear = 1'b0;
  logic i_osc_tick = 1'b0;
  logic i_osc_fail = 1'b0;
  scmr_pkg::scmr_rst_src_s i_rst_src = '0;
  logic o_self_clock_mode, o_pll_enable, o_voltage_regulator_enable, o_pll_clock_select;
  logic o_system_clock_pll, o_clocks_released, o_stopped, o_self_clock_irq_flag;
  logic o_self_clock_wake_irq, o_reset_req, o_clock_monitor_reset;
  logic [15:0] o_reset_vector;
  scmr_pkg::scmr_cause_s o_reset_cause;
  logic [5:0] o_check_windows;
  logic s_scm, s_rel, s_req, s_cmr;
  logic [15:0] s_vec;
  int miscompares = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_cmr = 0;
  int n_scmr = 0;
  // Rows: {monitor, self-clock, irq enables} -> {scm, flag, wake irq, monitor reset, pll clock}
  logic [7:0] rows [4] = '{8'h00, 8'h82, 8'hd9, 8'hfd};
  // Reset sources {power, low voltage, external, watchdog}, {lvd en, lvd reset en, rate}
  logic [3:0] rs_src [6] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h1, 4'h8};
  logic [4:0] rs_cfg [6] = '{5'h00, 5'h03, 5'h10, 5'h18, 5'h03, 5'h00};
  logic [15:0] rs_vec [6] = '{16'h0, 16'hfffa, 16'h0, 16'hfffe, 16'hfffa, 16'hfffe};

  always #4 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_reset_req === 1'b1) n_req <= n_req + 1;
    if (o_clock_monitor_reset === 1'b1) n_cmr <= n_cmr + 1;
    if (s_cmr === 1'b1) n_scmr <= n_scmr + 1;
  end

  scmr_stop_recovery #(.CHECK_WINDOW_CYCLES(WIN)) u_dut (.*);
  scmr_stop_recovery #(.CHECK_WINDOW_CYCLES(WIN_S)) u_dut_short (.*,
    .o_self_clock_mode(s_scm), .o_pll_enable(), .o_voltage_regulator_enable(), .o_pll_clock_select(),
    .o_system_clock_pll(), .o_clocks_released(s_rel), .o_stopped(),
    .o_self_clock_irq_flag(), .o_self_clock_wake_irq(), .o_reset_req(s_req),
    .o_clock_monitor_reset(s_cmr), .o_reset_vector(s_vec), .o_reset_cause(),
    .o_check_windows());

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic do_reset();
    i_rst = 1'b1;
    cyc(10);
    i_rst = 1'b0;
  endtask
  task automatic pulse_stop(input logic pseudo);
    i_cfg.pseudo_stop_select = pseudo;
    i_stop_req = 1'b1;
    cyc(1);
    i_stop_req = 1'b0;
    cyc(1);
  endtask
  task automatic pulse_wake();
    i_wake_irq = 1'b1;
    cyc(1);
    i_wake_irq = 1'b0;
    cyc(1);
  endtask
  // Bounded wait; running out is a failure and ends the run
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim, output int took);
    for (took = 0; took < lim && sig !== lvl; took++) begin
      cyc(1);
    end
    if (sig !== lvl) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, sig, lvl);
      report_and_stop();
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int base;
    int took;
    do_reset();
    chk(o_reset_vector, 16'hfffe);
    chkb(o_stopped, 1'b0);
    chkb(o_voltage_regulator_enable, 1'b1);
    foreach (rows[r]) begin
      do_reset();
      {i_cfg.clock_monitor_enable, i_cfg.self_clock_mode_enable,
        i_cfg.self_clock_irq_enable} = rows[r][7:5];
      pulse_stop(1'b1);
      base = n_cmr;
      i_osc_fail = 1'b1;
      cyc(1);
      i_osc_fail = 1'b0;
      chkb(o_self_clock_mode, rows[r][4]);
      chkb(o_self_clock_irq_flag, rows[r][3]);
      chkb(o_self_clock_wake_irq, rows[r][2]);
      pulse_wake();
      // The pulse counter trails the pulse by one edge, so look after the wake
      chk(16'(n_cmr - base), {15'h0, rows[r][1]});
      chkb(o_stopped, 1'b0);
      chkb(o_system_clock_pll, rows[r][0]);
    end
    // Loss without recovery, then recovery while still stopped
    do_reset();
    i_cfg = '0;
    i_cfg.clock_monitor_enable = 1'b1;
    i_cfg.self_clock_mode_enable = 1'b1;
    pulse_stop(1'b1);
    i_osc_fail = 1'b1;
    cyc(1);
    i_osc_fail = 1'b0;
    cyc(2 * WIN + 100);
    chkb(o_self_clock_mode, 1'b1);
    chkb(o_stopped, 1'b1);
    chk({10'h0, o_check_windows}, 16'h0002);
    i_osc_tick = 1'b1;
    wait_lvl(o_self_clock_mode, 1'b0, 3 * WIN, took);
    chkb(took >= 4096, 1'b1);
    chkb(o_stopped, 1'b1);
    chkb(o_pll_enable, 1'b0);
    chkb(o_voltage_regulator_enable, 1'b0);
    pulse_wake();
    chkb(o_system_clock_pll, 1'b0);
    // Full stop: blind monitor, interrupt wake with a good clock
    do_reset();
    i_pll_clock_select_set = 1'b1;
    cyc(1);
    i_pll_clock_select_set = 1'b0;
    chkb(o_pll_clock_select, 1'b1);
    pulse_stop(1'b0);
    i_osc_fail = 1'b1;
    cyc(3);
    i_osc_fail = 1'b0;
    chkb(o_stopped, 1'b1);
    chkb(o_self_clock_mode, 1'b0);
    pulse_wake();
    wait_lvl(o_clocks_released, 1'b1, 3 * WIN, took);
    chkb(o_self_clock_mode, 1'b0);
    chkb(o_pll_clock_select, 1'b0);
    // External reset during full stop
    pulse_stop(1'b0);
    i_rst_src.external = 1'b1;
    cyc(1);
    i_rst_src.external = 1'b0;
    wait_lvl(o_reset_req, 1'b1, 3 * WIN, took);
    chk(o_reset_vector, 16'hfffe);
    chk({13'h0, o_reset_cause}, 16'h0004);
    chkb(o_clocks_released, 1'b1);
    // Reset sources and their local enables in run
    do_reset();
    i_cfg = '0;
    foreach (rs_src[k]) begin
      base = n_req;
      {i_cfg.low_voltage_detect_enable, i_cfg.low_voltage_reset_enable,
        i_cfg.watchdog_rate_field} = rs_cfg[k];
      i_rst_src = rs_src[k];
      cyc(1);
      i_rst_src = '0;
      if (rs_vec[k] == 16'h0) begin
        cyc(20);
        chk(16'(n_req - base), 16'h0);
      end else begin
        wait_lvl(o_reset_req, 1'b1, 3 * WIN, took);
        chk(o_reset_vector, rs_vec[k]);
      end
      cyc(2);
    end
    // Full-stop check window timeout on the short-window instance
    i_osc_tick = 1'b0;
    for (int m = 0; m < 2; m++) begin
      do_reset();
      i_cfg = '0;
      i_cfg.clock_monitor_enable = 1'b1;
      i_cfg.self_clock_mode_enable = m[0];
      base = n_scmr;
      pulse_stop(1'b0);
      pulse_wake();
      wait_lvl(s_rel, 1'b1, 60 * WIN_S, took);
      chkb(took > 48 * WIN_S && took < 52 * WIN_S, 1'b1);
      cyc(2);
      chkb(s_scm, m[0]);
      chk(16'(n_scmr - base), {15'h0, ~m[0]});
      chk(s_vec, m[0] ? 16'hfffe : 16'hfffc);
    end
    report_and_stop();
  end
endmodule
